// ==== shared/acwd_pkg.sv ====
// Package for the front-end control word decoder: word layout, register map, divider tables.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package acwd_pkg;

    localparam int          WORD_W        = 16;
    localparam int          CMD_FLAG_BIT  = 15;
    localparam int          RW_BIT        = 14;
    localparam int          DEV_HI        = 13;
    localparam int          DEV_LO        = 11;
    localparam int          REG_HI        = 10;
    localparam int          REG_LO        = 8;
    localparam int          DATA_HI       = 7;

    localparam logic [2:0]  REG_MODE      = 3'h0;
    localparam logic [2:0]  REG_CLOCK     = 3'h1;
    localparam logic [2:0]  REG_POWER     = 3'h2;
    localparam logic [2:0]  REG_PAIR12    = 3'h3;
    localparam logic [2:0]  REG_PAIR34    = 3'h4;
    localparam logic [7:0]  REG_RESET_VAL = 8'h00;

    // Mode register fields
    localparam int          MODE_DATA_BIT = 0;
    localparam int          MODE_MIX_BIT  = 1;
    localparam int          MODE_LB_BIT   = 3;
    localparam int          MODE_CNT_LO   = 4;
    localparam int          MODE_SWR_BIT  = 7;
    // Clock register fields
    localparam int          CLK_DEC_LO    = 0;
    localparam int          CLK_SCD_LO    = 2;
    localparam int          CLK_MCD_LO    = 4;
    localparam int          CLK_ECHO_BIT  = 7;
    // Power register fields
    localparam int          PWR_GLOBAL_BIT = 0;
    localparam int          PWR_REF_BIT    = 5;
    localparam int          PWR_REFERENCE_OUTPUT_PIN_BIT = 6;
    localparam logic [7:0]  PWR_WMASK      = 8'h61;
    localparam logic [7:0]  MODE_WMASK     = 8'hfb;
    // Channel pair fields
    localparam int          PAIR_LO_GAIN  = 0;
    localparam int          PAIR_LO_PWR   = 3;
    localparam int          PAIR_HI_GAIN  = 4;
    localparam int          PAIR_HI_PWR   = 7;

    // Divider tables
    localparam logic [11:0] DEC_DIV_0     = 12'h800;
    localparam logic [11:0] DEC_DIV_1     = 12'h400;
    localparam logic [11:0] DEC_DIV_2     = 12'h200;
    localparam logic [11:0] DEC_DIV_3     = 12'h100;
    localparam logic [3:0]  SCK_DIV_0     = 4'h8;
    localparam logic [3:0]  SCK_DIV_1     = 4'h4;
    localparam logic [3:0]  SCK_DIV_2     = 4'h2;
    localparam logic [3:0]  SCK_DIV_3     = 4'h1;
    localparam logic [2:0]  MCD_MAX_CODE  = 3'h4;
    localparam int          SWRESET_CYC   = 4;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] clk;
        logic [7:0] pwr;
        logic [7:0] pair12;
        logic [7:0] pair34;
    } acwd_regs_t;

    typedef struct packed {
        logic       decim_tick;
        logic       sclk_tick;
        logic       mclk_tick;
    } acwd_ticks_t;

endpackage

// ==== logic/acwd_divider.sv ====
// Divide-by-N enable generator; one-cycle tick every N enables.
// Assumes clk_in and synchronous active-high sys_rst_in.
`timescale 1ns/1ns
module acwd_divider import acwd_pkg::*; #(
    parameter int W = 12
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         en_in,
    input  wire logic [W-1:0] div_in,
    output logic              tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } acwd_div_st_t;

    acwd_div_st_t st_q;
    acwd_div_st_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (en_in) begin
            if (st_q.cnt + W'(1) >= div_in) begin
                st_d.cnt  = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = st_q.tick;
endmodule

// ==== logic/acwd_decoder.sv ====
// Control word decoder and control register file of the analog front end serial port.
// Assumes serial data sampled on the system clock at serial link clock ticks; no bus.
//
// Contract
// - Bit 15 set marks a valid control word; clear is invalid in program mode.
// - Write with address zero stores data field into the selected register.
// - Read with address zero returns register contents in the data field, sent out.
// - Device is addressed only when the device address field is zero.
// - Nonzero device address is decremented and the word forwarded otherwise unchanged.
// - Register address field selects one of five registers; addresses 5 to 7 read zero and ignore writes.
// - Low eight bits carry the register value, used only when addressed.
// - Mode bit 0 clear is program mode; set is data mode ignoring input.
// - Mode bit 1 enables mixed mode, accepting flagged control words.
// - Mode bit 3 enables serial loop-back.
// - Mode bits 6:4 hold the cascaded device count.
// - Writing mode bit 7 starts a software reset.
// - Clock bits 1:0 select the decimation rate.
// - Clock bits 3:2 select the serial clock divider.
// - Clock bits 6:4 select the master clock divider.
// - Clock bit 7 enables control echo.
// - Power bit 0 is global power up.
// - Power bit 5 powers the reference.
// - Power bit 6 enables the reference output pin.
// - Pair registers hold 3-bit gains at bits 2:0 and 6:4.
// - Pair registers hold ADC power bits 3 and 7.
// - Decimation codes give divide by 2048, 1024, 512, 256.
// - Serial codes give divide by 8, 4, 2, 1.
// - Master codes 0 to 4 divide by 1 to 5; others by one.
// - Registers update on the falling edge of the serial link clock.
`timescale 1ns/1ns
module acwd_decoder import acwd_pkg::*; (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        serial_data_in,
    input  wire logic        frame_sync_in,
    output logic             serial_data_out,
    output logic             frame_sync_out,
    output logic             serial_link_clock_out,
    output logic             internal_master_tick_out,
    output logic             sample_tick_out,
    output logic             operating_mode_sel_out,
    output logic             mixed_mode_enable_out,
    output logic             loopback_enable_out,
    output logic [2:0]       cascade_count_out,
    output logic             control_echo_enable_out,
    output logic             global_power_up_out,
    output logic             reference_power_on_out,
    output logic             reference_output_enable_out,
    output logic [11:0]      adc_gain_out,
    output logic [3:0]       adc_power_on_out,
    output logic             sw_reset_active_out
);
    typedef enum logic [1:0] {
        S_IDLE,
        S_SHIFT_IN,
        S_SHIFT_OUT
    } acwd_state_t;

    typedef struct packed {
        acwd_state_t        state;
        acwd_regs_t         regs;
        logic [WORD_W-1:0]  sreg;
        logic [3:0]         bitcnt;
        logic               sclk;
        logic               sdo;
        logic               fso;
        logic [2:0]         swr_cnt;
        logic               swr;
    } acwd_st_t;

    acwd_st_t    st_q;
    acwd_st_t    st_d;
    acwd_ticks_t ticks;
    logic [2:0]  mdiv;
    logic [3:0]  sdiv;
    logic [11:0] ddiv;
    logic        fall;
    logic        addressed;
    logic        accept;
    logic [7:0]  rd_val;
    logic        rst_all;

    assign rst_all = sys_rst_in | st_q.swr;

    // Master, serial and decimation clock divider tables
    always_comb begin
        if (st_q.regs.clk[CLK_MCD_LO +: 3] <= MCD_MAX_CODE) begin
            mdiv = st_q.regs.clk[CLK_MCD_LO +: 3] + 3'h1;
        end else begin
            mdiv = 3'h1;
        end
        case (st_q.regs.clk[CLK_SCD_LO +: 2])
            2'h0:    sdiv = SCK_DIV_0;
            2'h1:    sdiv = SCK_DIV_1;
            2'h2:    sdiv = SCK_DIV_2;
            default: sdiv = SCK_DIV_3;
        endcase
        case (st_q.regs.clk[CLK_DEC_LO +: 2])
            2'h0:    ddiv = DEC_DIV_0;
            2'h1:    ddiv = DEC_DIV_1;
            2'h2:    ddiv = DEC_DIV_2;
            default: ddiv = DEC_DIV_3;
        endcase
    end

    acwd_divider #(.W(3)) u_mdiv (
        .clk_in     (clk_in),
        .sys_rst_in (rst_all),
        .en_in      (1'b1),
        .div_in     (mdiv),
        .tick_out   (ticks.mclk_tick)
    );

    // Half-period ticks: serial clock toggles once per divided period
    acwd_divider #(.W(4)) u_sdiv (
        .clk_in     (clk_in),
        .sys_rst_in (rst_all),
        .en_in      (ticks.mclk_tick),
        .div_in     (sdiv),
        .tick_out   (ticks.sclk_tick)
    );

    acwd_divider #(.W(12)) u_ddiv (
        .clk_in     (clk_in),
        .sys_rst_in (rst_all),
        .en_in      (ticks.mclk_tick),
        .div_in     (ddiv),
        .tick_out   (ticks.decim_tick)
    );

    assign fall      = ticks.sclk_tick & st_q.sclk;
    assign addressed = (st_q.sreg[DEV_HI:DEV_LO] == 3'h0);

    // Flagged control words honoured in program mode or in mixed mode
    assign accept = st_q.sreg[CMD_FLAG_BIT]
                  & (~st_q.regs.mode[MODE_DATA_BIT]
                     | st_q.regs.mode[MODE_MIX_BIT]);

    always_comb begin
        case (st_q.sreg[REG_HI:REG_LO])
            REG_MODE:   rd_val = st_q.regs.mode;
            REG_CLOCK:  rd_val = st_q.regs.clk;
            REG_POWER:  rd_val = st_q.regs.pwr;
            REG_PAIR12: rd_val = st_q.regs.pair12;
            REG_PAIR34: rd_val = st_q.regs.pair34;
            default:    rd_val = 8'h00;
        endcase
    end

    always_comb begin
        st_d = st_q;
        if (ticks.sclk_tick) begin
            st_d.sclk = ~st_q.sclk;
        end
        if (st_q.swr) begin
            st_d.swr_cnt = st_q.swr_cnt - 3'h1;
            if (st_q.swr_cnt == 3'h1) begin
                st_d.swr = 1'b0;
            end
        end
        st_d.fso = 1'b0;
        if (fall) begin
            case (st_q.state)
                S_IDLE: begin
                    st_d.sreg = {st_q.sreg[WORD_W-2:0], serial_data_in};
                    if (frame_sync_in) begin
                        st_d.bitcnt = 4'h1;
                        st_d.state  = S_SHIFT_IN;
                    end
                end
                S_SHIFT_IN: begin
                    st_d.sreg   = {st_q.sreg[WORD_W-2:0], serial_data_in};
                    st_d.bitcnt = st_q.bitcnt + 4'h1;
                    if (st_q.bitcnt == 4'hf) begin
                        st_d.state = S_SHIFT_OUT;
                    end
                end
                S_SHIFT_OUT: begin
                    st_d.state = S_IDLE;
                    if (accept) begin
                        if (!addressed) begin
                            st_d.sreg[DEV_HI:DEV_LO] = st_q.sreg[DEV_HI:DEV_LO] - 3'h1;
                            st_d.fso                 = 1'b1;
                        end else if (st_q.sreg[RW_BIT]) begin
                            st_d.sreg[DATA_HI:0] = rd_val;
                            st_d.fso             = 1'b1;
                        end else begin
                            case (st_q.sreg[REG_HI:REG_LO])
                                REG_MODE: begin
                                    st_d.regs.mode = st_q.sreg[DATA_HI:0] & MODE_WMASK;
                                    if (st_q.sreg[MODE_SWR_BIT]) begin
                                        st_d.swr     = 1'b1;
                                        st_d.swr_cnt = 3'(SWRESET_CYC);
                                    end
                                end
                                REG_CLOCK:  st_d.regs.clk    = st_q.sreg[DATA_HI:0];
                                REG_POWER:  st_d.regs.pwr    = st_q.sreg[DATA_HI:0] & PWR_WMASK;
                                REG_PAIR12: st_d.regs.pair12 = st_q.sreg[DATA_HI:0];
                                REG_PAIR34: st_d.regs.pair34 = st_q.sreg[DATA_HI:0];
                                default:    st_d.regs        = st_q.regs;
                            endcase
                            if (st_q.regs.clk[CLK_ECHO_BIT]) begin
                                st_d.fso = 1'b1;
                            end
                        end
                    end else if (st_q.regs.mode[MODE_LB_BIT]) begin
                        st_d.fso = 1'b1;
                    end
                end
                default: st_d.state = S_IDLE;
            endcase
        end
        st_d.sdo = st_q.sreg[WORD_W-1];
        if (sys_rst_in) begin
            st_d.swr = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else if (st_q.swr && st_q.swr_cnt == 3'h1) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            serial_data_out             <= 1'b0;
            frame_sync_out              <= 1'b0;
            serial_link_clock_out       <= 1'b0;
            internal_master_tick_out    <= 1'b0;
            sample_tick_out             <= 1'b0;
            operating_mode_sel_out      <= 1'b0;
            mixed_mode_enable_out       <= 1'b0;
            loopback_enable_out         <= 1'b0;
            cascade_count_out           <= 3'h0;
            control_echo_enable_out     <= 1'b0;
            global_power_up_out         <= 1'b0;
            reference_power_on_out      <= 1'b0;
            reference_output_enable_out <= 1'b0;
            adc_gain_out                <= 12'h000;
            adc_power_on_out            <= 4'h0;
            sw_reset_active_out         <= 1'b0;
        end else begin
            serial_data_out             <= st_q.sdo;
            frame_sync_out              <= st_q.fso;
            serial_link_clock_out       <= st_q.sclk;
            internal_master_tick_out    <= ticks.mclk_tick;
            sample_tick_out             <= ticks.decim_tick;
            operating_mode_sel_out      <= st_q.regs.mode[MODE_DATA_BIT];
            mixed_mode_enable_out       <= st_q.regs.mode[MODE_MIX_BIT];
            loopback_enable_out         <= st_q.regs.mode[MODE_LB_BIT];
            cascade_count_out           <= st_q.regs.mode[MODE_CNT_LO +: 3];
            control_echo_enable_out     <= st_q.regs.clk[CLK_ECHO_BIT];
            global_power_up_out         <= st_q.regs.pwr[PWR_GLOBAL_BIT];
            reference_power_on_out      <= st_q.regs.pwr[PWR_REF_BIT];
            reference_output_enable_out <= st_q.regs.pwr[PWR_REFERENCE_OUTPUT_PIN_BIT];
            adc_gain_out                <= {st_q.regs.pair34[PAIR_HI_GAIN +: 3], st_q.regs.pair34[PAIR_LO_GAIN +: 3],
                                            st_q.regs.pair12[PAIR_HI_GAIN +: 3], st_q.regs.pair12[PAIR_LO_GAIN +: 3]};
            adc_power_on_out            <= {st_q.regs.pair34[PAIR_HI_PWR], st_q.regs.pair34[PAIR_LO_PWR],
                                            st_q.regs.pair12[PAIR_HI_PWR], st_q.regs.pair12[PAIR_LO_PWR]};
            sw_reset_active_out         <= st_q.swr;
        end
    end

    AST_SCLK_TOGGLE_ON_TICK: assert property (@(posedge clk_in) disable iff (rst_all)
        ticks.sclk_tick |=> st_q.sclk != $past(st_q.sclk)) else $error("Serial clock did not toggle");
    AST_NO_WRITE_MID_FRAME: assert property (@(posedge clk_in) disable iff (rst_all)
        st_q.state != S_SHIFT_OUT |=> $stable(st_q.regs.pwr)) else $error("Register changed mid frame");
    AST_FORWARD_DEC: assert property (@(posedge clk_in) disable iff (rst_all)
        fall && st_q.state == S_SHIFT_OUT && accept && !addressed
        |=> st_q.sreg[DEV_HI:DEV_LO] == $past(st_q.sreg[DEV_HI:DEV_LO]) - 3'h1) else $error("Address not decremented");
    AST_WRITE_PWR: assert property (@(posedge clk_in) disable iff (rst_all)
        fall && st_q.state == S_SHIFT_OUT && accept && addressed && !st_q.sreg[RW_BIT]
        && st_q.sreg[REG_HI:REG_LO] == REG_POWER
        |=> st_q.regs.pwr == ($past(st_q.sreg[DATA_HI:0]) & PWR_WMASK)) else $error("Power write lost");
    AST_READ_DATA: assert property (@(posedge clk_in) disable iff (rst_all)
        fall && st_q.state == S_SHIFT_OUT && accept && addressed && st_q.sreg[RW_BIT]
        |=> st_q.sreg[DATA_HI:0] == $past(rd_val) ##0 st_q.fso) else $error("Read data not loaded");
    AST_DATA_MODE_IGNORE: assert property (@(posedge clk_in) disable iff (rst_all)
        st_q.regs.mode[MODE_DATA_BIT] && !st_q.regs.mode[MODE_MIX_BIT] |-> !accept) else $error("Data mode accepted");
    AST_FLAG_LOW_IGNORED: assert property (@(posedge clk_in) disable iff (rst_all)
        !st_q.sreg[CMD_FLAG_BIT] |-> !accept) else $error("Unflagged word accepted");
    AST_SWRESET_CLEARS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(st_q.swr) |-> ##4 st_q.regs == '0) else $error("Software reset did not clear");
endmodule

// ==== dv/acwd_host_model.sv ====
// Host serial port model: shifts 16-bit control words into the front end, MSB first.
// Assumes the front end drives the serial link clock and samples data at its falling edge.
`timescale 1ns/1ns
module acwd_host_model (
    input  wire logic clk_in,
    input  wire logic sclk_in,
    output logic      data_out,
    output logic      fsync_out
);
    initial begin
        data_out  = 1'b0;
        fsync_out = 1'b0;
    end
    // Bits launch just after a serial clock rise, so they are settled at the fall
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            @(posedge sclk_in);
            @(posedge clk_in);
            #2;
            fsync_out = (i == 15);
            data_out  = w[i];
        end
        @(posedge sclk_in);
        @(posedge clk_in);
        #2;
        data_out = ~w[0];
    endtask
endmodule

// ==== dv/afe_control_word_decoder_bench.sv ====
// Self-checking bench for the front-end control word decoder.
// Assumes acwd_pkg, acwd_decoder and acwd_host_model are compiled first.
`timescale 1ns/1ns
module afe_control_word_decoder_bench import acwd_pkg::*;;
    localparam int LIMIT_CYC = 95000;
    logic        clk_in, sys_rst_in, sdi, fsi, sdo, fso, sclk, mtick, stick;
    logic        opm, mix, lb, echo, global_power_up, refp, refo, swr, lax;
    logic [2:0]  casc;
    logic [11:0] gain;
    logic [3:0]  pwr;
    logic [25:0] bund, rq[$];
    logic [15:0] wq[$];
    logic [31:0] seed;
    logic [7:0]  d;
    logic [7:0]  ctab [8] = '{8'h00, 8'h15, 8'h26, 8'h37, 8'h47, 8'h53, 8'h63, 8'h71};
    acwd_regs_t  er;
    int          bad_count, tests_run, md;
    assign bund = {opm, mix, lb, casc, echo, global_power_up, refp, refo, gain, pwr};

    acwd_decoder DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .serial_data_in(sdi), .frame_sync_in(fsi),
        .serial_data_out(sdo), .frame_sync_out(fso), .serial_link_clock_out(sclk),
        .internal_master_tick_out(mtick), .sample_tick_out(stick), .operating_mode_sel_out(opm),
        .mixed_mode_enable_out(mix), .loopback_enable_out(lb), .cascade_count_out(casc),
        .control_echo_enable_out(echo), .global_power_up_out(global_power_up), .reference_power_on_out(refp),
        .reference_output_enable_out(refo), .adc_gain_out(gain), .adc_power_on_out(pwr),
        .sw_reset_active_out(swr));
    acwd_host_model host (.clk_in(clk_in), .sclk_in(sclk), .data_out(sdi), .fsync_out(fsi));

    function automatic logic [25:0] pack_regs(acwd_regs_t r);
        return {r.mode[0], r.mode[1], r.mode[3], r.mode[6:4], r.clk[7], r.pwr[0], r.pwr[5], r.pwr[6],
                r.pair34[6:4], r.pair34[2:0], r.pair12[6:4], r.pair12[2:0],
                r.pair34[7], r.pair34[3], r.pair12[7], r.pair12[3]};
    endfunction

    task automatic cmp_regs(logic [25:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL regs exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_word(logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL word exp %h got %h", e, g);
        end
    endtask
    // Period of a tick or clock output in system clocks, after one settling period
    // A pulse output counts every high cycle as an event, a clock output only its rises
    task automatic cmp_period(string what, ref logic s, input bit pulse, input int e);
        int   k;
        int   n;
        logic p;
        k = 0;
        n = 0;
        p = 1'b1;
        while (k < 3) begin
            @(posedge clk_in);
            #1;
            n++;
            if (s === 1'b1 && (pulse || p === 1'b0)) begin
                k++;
                if (k < 3) n = 0;
            end
            p = s;
        end
        tests_run++;
        if (n != e) begin
            bad_count++;
            $display("FAIL %s exp %0d got %0d", what, e, n);
        end
    endtask

    task automatic xfer(logic [15:0] w);
        host.send_word(w);
        repeat (18) @(posedge sclk);
    endtask
    task automatic wr(logic [2:0] r, logic [7:0] v);
        logic [25:0] old;
        old = pack_regs(er);
        if (r == REG_MODE && v[7]) er = '0;
        else if (r <= REG_PAIR34) er[39-8*int'(r) -: 8] = v;
        if (pack_regs(er) !== old) rq.push_back(pack_regs(er));
        xfer({2'b10, 3'h0, r, v});
    endtask
    task automatic rd(logic [2:0] r);
        wq.push_back({2'b11, 3'h0, r, (r <= REG_PAIR34) ? er[39-8*int'(r) -: 8] : 8'h00});
        xfer({2'b11, 3'h0, r, 8'h00});
    endtask
    task automatic fwd(logic [2:0] dv, logic [11:0] rest);
        wq.push_back({1'b1, rest[11], dv - 3'h1, rest[10:0]});
        xfer({1'b1, rest[11], dv, rest[10:0]});
    endtask

    task automatic give_verdict();
        if (rq.size() != 0 || wq.size() != 0) begin
            bad_count++;
            $display("FAIL queues exp 0 got %0d", rq.size() + wq.size());
        end
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    initial begin : reg_watch
        @(negedge sys_rst_in);
        forever begin
            @(bund);
            @(posedge clk_in);
            #1;
            if (rq.size() == 0) begin
                bad_count++;
                $display("FAIL regs exp none got %h", bund);
            end else cmp_regs(rq.pop_front(), bund);
        end
    end

    initial begin : word_watch
        logic [15:0] w;
        forever begin
            @(posedge clk_in);
            #1;
            if (fso === 1'b1 && wq.size() != 0) begin
                for (int i = 15; i >= 0; i--) begin
                    @(posedge sclk);
                    w[i] = sdo;
                end
                cmp_word(wq.pop_front(), w);
            end else if (fso === 1'b1 && !lax) begin
                bad_count++;
                $display("FAIL word exp none got pulse");
            end
        end
    end

    initial begin
        #(LIMIT_CYC * 20);
        bad_count++;
        $display("FAIL watchdog exp done got timeout");
        give_verdict();
    end

    initial begin
        seed       = 32'h6566;
        sys_rst_in = 1'b1;
        lax        = 1'b0;
        er         = '0;
        bad_count  = 0;
        tests_run  = 0;
        repeat (8) @(posedge clk_in);
        #2;
        sys_rst_in = 1'b0;
        for (int r = 0; r < 8; r++) rd(3'(r));
        d = $random(seed);
        wr(REG_PAIR12, d);
        d = $random(seed);
        wr(REG_PAIR34, d);
        d = $random(seed);
        wr(REG_POWER, d & PWR_WMASK);
        wr(REG_MODE, 8'h70);
        wr(3'h5, 8'h5a);
        xfer({2'b00, 3'h0, REG_POWER, 8'h00});
        for (int r = 0; r < 8; r++) rd(3'(r));
        for (int v = 1; v < 8; v++) fwd(3'(v), 12'($random(seed)));
        wr(REG_MODE, 8'h00);
        foreach (ctab[i]) begin
            wr(REG_CLOCK, ctab[i]);
            md = (ctab[i][6:4] <= MCD_MAX_CODE) ? int'(ctab[i][6:4]) + 1 : 1;
            cmp_period("mclk", mtick, 1'b1, md);
            cmp_period("sample", stick, 1'b1, md * (2048 >> ctab[i][1:0]));
            cmp_period("sclk", sclk, 1'b0, 2 * md * (8 >> ctab[i][3:2]));
        end
        lax = 1'b1;
        wr(REG_CLOCK, 8'h80);
        wr(REG_CLOCK, 8'h00);
        wr(REG_MODE, 8'h08);
        wq.push_back(16'h0123);
        xfer(16'h0123);
        wr(REG_MODE, 8'h00);
        lax = 1'b0;
        wr(REG_MODE, 8'h80);
        lax = 1'b1;
        wr(REG_MODE, 8'h03);
        d = $random(seed);
        wr(REG_POWER, d & PWR_WMASK);
        xfer({2'b00, 3'h0, REG_PAIR12, 8'hff});
        wr(REG_MODE, 8'h01);
        xfer({2'b10, 3'h0, REG_PAIR12, 8'hff});
        er = '0;
        rq.push_back('0);
        @(posedge clk_in);
        #2;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        #2;
        sys_rst_in = 1'b0;
        lax = 1'b0;
        rd(REG_POWER);
        give_verdict();
    end
endmodule
